// [src/lfv_params.svh]
`ifndef LFV_PARAMS_SVH
`define LFV_PARAMS_SVH
// ************************************************************
// Clock, prescaler and timing figures.
// ************************************************************
`define LFV_CLK_MHZ    200
`define LFV_TICK_US    1
`define LFV_REC_S      4
`define LFV_SHORT_MS   90
`define LFV_SOFT_US    200
`define LFV_TOUT_NS    6500
`define LFV_DLY_NS     250
`define LFV_LEB_NS     300
`define LFV_WS_CYCLES  4
// ************************************************************
// Set-point steps in percent, falling and rising.
// ************************************************************
`define LFV_DN0 78
`define LFV_DN1 50
`define LFV_DN2 30
`define LFV_DN3 15
`define LFV_DN4 6
`define LFV_UP0 75
`define LFV_UP1 53
`define LFV_UP2 33
`define LFV_UP3 20
`define LFV_UP4 8
// ************************************************************
// Reset values.
// ************************************************************
`define LFV_VALLEY_RST 5'h01
`define LFV_BAND_RST   3'h0
`endif

// [src/lfv_pkg.sv]
package lfv_pkg;
    typedef enum logic [2:0] {ST_OFF, ST_FAULT, ST_RUN, ST_STOP, ST_AR, ST_LATCH} lfv_state_t;
    typedef logic [4:0] lfv_valley_t;
    typedef logic [2:0] lfv_band_t;
    localparam lfv_valley_t LFV_VLL [6] = '{5'h01, 5'h02, 5'h04, 5'h07, 5'h0b, 5'h0d};
    localparam lfv_valley_t LFV_VHA [6] = '{5'h02, 5'h03, 5'h05, 5'h08, 5'h0c, 5'h0f};
    localparam lfv_valley_t LFV_VHB [6] = '{5'h03, 5'h04, 5'h06, 5'h09, 5'h0d, 5'h10};
endpackage : lfv_pkg

// [src/lfv_ctrl.sv]
`timescale 1ns/1ps
`include "lfv_params.svh"
// Notes on behaviour
// - Auto-recovery variant: four short cycles stop drive, wait four seconds, restart.
// - Latched variant: four short cycles stop drive and latch the device stopped.
// - Short latch clears on supply off, dimming low four seconds, or brown-out rise.
// - Clearing the short latch always leads into off mode.
// - Dimming below enable level disables gate drive pulses.
// - Dimming drop ramps peak command to zero within 200 us, then halts.
// - Dimming low for four seconds continuously enters off mode.
// - Off mode exits only when dimming exceeds enable level plus hysteresis.
// - Supply over-voltage stops drive: auto-recovery or latched per variant.
// - Over-voltage recovery waits four seconds, restarts via off then fault mode.
// - Over-voltage latch clears on the same three events, then off mode.
// - Valley chosen from line and dimming level, held until they change.
// - Full current: valley one low line; two or three at high line.
// - Line is high above 2.4 V, low again below 2.3 V.
// - Valley steps at fixed set-point percentages with separate rising thresholds.
// - A valley registers when zero-cross sense falls through its threshold.
// - A fixed 250 ns delay follows a valley before switch turn-on.
// - Sense low for 6.5 us yields a timeout pulse counted as valley.
// - Short timer reaching 90 ms stops pulsing, waits four seconds, restarts.
// - Short timer is disabled while dimming is below enable level.
// - Line feed-forward offset is applied only while the switch is on.
// - Winding short comparator counts only inside the blanking window.
// - Fault mode checks current sense pin; short starts recovery, else pulses.
module lfv_ctrl
    import lfv_pkg::*;
#(
    parameter int PK_W        = 8,
    parameter int REC_TICKS   = `LFV_REC_S * 1000000 / `LFV_TICK_US,
    parameter int SHORT_TICKS = `LFV_SHORT_MS * 1000 / `LFV_TICK_US,
    parameter int LEB_NS      = `LFV_LEB_NS
) (
    // Clock and reset.
    input  wire logic              clk_sys_i,
    input  wire logic              nrst_i,
    // Comparator and status pins.
    input  wire logic              latched_variant_i,
    input  wire logic              cs_short_cmp_i,
    input  wire logic              cs_peak_cmp_i,
    input  wire logic              cs_pin_short_i,
    input  wire logic              zcd_valley_cmp_i,
    input  wire logic              zcd_short_cmp_i,
    input  wire logic              dim_en_cmp_i,
    input  wire logic              dim_hys_cmp_i,
    input  wire logic              supply_ovp_cmp_i,
    input  wire logic              supply_off_cmp_i,
    input  wire logic              line_low_fault_i,
    input  wire logic              line_hi_cmp_i,
    input  wire logic              line_lo_cmp_i,
    input  wire logic              thermal_shutdown_i,
    // Set-points from core logic.
    input  wire logic [6:0]        dim_level_i,
    input  wire logic [PK_W-1:0]   peak_set_i,
    // Drive and status.
    output logic                   gate_drive_out_o,
    output logic                   lff_offset_en_o,
    output logic [PK_W-1:0]        peak_cmd_o,
    output logic [4:0]             valley_sel_o,
    output logic                   high_line_o,
    output logic                   off_mode_o,
    output logic                   fault_mode_o,
    output logic                   run_mode_o,
    output logic                   ar_mode_o,
    output logic                   latched_o,
    output logic                   winding_short_protect_o,
    output logic                   short_timer_trip_o
);
    localparam int TICK_CYC = `LFV_CLK_MHZ * `LFV_TICK_US;
    localparam int TOUT_CYC = `LFV_TOUT_NS * `LFV_CLK_MHZ / 1000;
    localparam int DLY_CYC  = (`LFV_DLY_NS * `LFV_CLK_MHZ + 999) / 1000;
    localparam int LEB_CYC  = (LEB_NS * `LFV_CLK_MHZ + 999) / 1000;
    localparam int SS_TICKS = `LFV_SOFT_US / `LFV_TICK_US;
    localparam int SS_STEP  = ((1 << PK_W) - 1 + SS_TICKS - 1) / SS_TICKS;
    localparam int TW = $clog2(TICK_CYC);
    localparam int OW = $clog2(TOUT_CYC);
    localparam int DW = $clog2(DLY_CYC + 1);
    localparam int LW = $clog2(LEB_CYC + 1);
    localparam int RW = $clog2(REC_TICKS + 1);
    localparam int SW = $clog2(SHORT_TICKS + 1);
    localparam logic [PK_W-1:0] STEP_V = PK_W'(SS_STEP);

    // ************************************************************
    // Valley selection functions.
    // ************************************************************
    function automatic lfv_band_t band_next(input lfv_band_t b, input logic [6:0] lv);
        logic [6:0] dn;
        logic [6:0] up;
        logic [6:0] pdn;
        dn = 7'h00;
        up = 7'h7f;
        pdn = 7'h00;
        case (b)
            3'h0: begin dn = 7'(`LFV_DN0); end
            3'h1: begin dn = 7'(`LFV_DN1); up = 7'(`LFV_UP0); pdn = 7'(`LFV_DN0); end
            3'h2: begin dn = 7'(`LFV_DN2); up = 7'(`LFV_UP1); pdn = 7'(`LFV_DN1); end
            3'h3: begin dn = 7'(`LFV_DN3); up = 7'(`LFV_UP2); pdn = 7'(`LFV_DN2); end
            3'h4: begin dn = 7'(`LFV_DN4); up = 7'(`LFV_UP3); pdn = 7'(`LFV_DN3); end
            default: begin up = 7'(`LFV_UP4); pdn = 7'(`LFV_DN4); end
        endcase
        // Rising needs the lower band's falling level too, so 75..78 cannot oscillate.
        if (b != 3'h5 && lv < dn) begin
            band_next = b + 3'h1;
        end else if (b != 3'h0 && lv > up && lv >= pdn) begin
            band_next = b - 3'h1;
        end else begin
            band_next = b;
        end
    endfunction : band_next

    function automatic lfv_valley_t valley_of(input lfv_band_t b, input logic hi,
                                              input logic lat);
        if (!hi) begin
            valley_of = LFV_VLL[b];
        end else if (lat) begin
            valley_of = LFV_VHA[b];
        end else begin
            valley_of = LFV_VHB[b];
        end
    endfunction : valley_of

    // ************************************************************
    // Input synchronisers and prescaler.
    // ************************************************************
    logic [13:0]       s1_q;
    logic [13:0]       s2_q;
    logic              strap_s, csh_s, cpk_s, cpin_s, zv_s, zs_s, den_s, dhys_s;
    logic              ovp_s, soff_s, bo_s, lhi_s, llo_s, tsd_s;
    logic [TW-1:0]     tick_cnt_q;
    logic              tick_q;
    logic              tick_wrap;

    assign {strap_s, csh_s, cpk_s, cpin_s, zv_s, zs_s, den_s, dhys_s,
            ovp_s, soff_s, bo_s, lhi_s, llo_s, tsd_s} = s2_q;
    assign tick_wrap = tick_cnt_q == TW'(TICK_CYC - 1);

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q       <= '0;
            s2_q       <= '0;
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            s1_q       <= {latched_variant_i, cs_short_cmp_i, cs_peak_cmp_i, cs_pin_short_i,
                           zcd_valley_cmp_i, zcd_short_cmp_i, dim_en_cmp_i, dim_hys_cmp_i,
                           supply_ovp_cmp_i, supply_off_cmp_i, line_low_fault_i,
                           line_hi_cmp_i, line_lo_cmp_i, thermal_shutdown_i};
            s2_q       <= s1_q;
            tick_cnt_q <= tick_wrap ? '0 : tick_cnt_q + 1'b1;
            tick_q     <= tick_wrap;
        end
    end

    // ************************************************************
    // Datapath wires.
    // ************************************************************
    lfv_state_t        state_q, state_d;
    logic [1:0]        init_q;
    logic              latched_q, bo_prev_q, zv_prev_q, ar_dim_q, line_hi_q, line_hi_d;
    lfv_band_t         band_q, band_d;
    logic [4:0]        valley_q, vcnt_q, vcnt_d;
    logic [OW-1:0]     tout_cnt_q, tout_cnt_d;
    logic [DW-1:0]     dly_cnt_q;
    logic [LW-1:0]     leb_cnt_q;
    logic [RW-1:0]     dl_cnt_q, dl_cnt_d, rec_cnt_q, rec_cnt_d;
    logic [SW-1:0]     sc_cnt_q, sc_cnt_d;
    logic [2:0]        ws_cnt_q, ws_cnt_d;
    logic              dly_act_q, dly_act_d, gate_q, gate_d, ws_hit_q, ws_hit_d;
    logic [PK_W-1:0]   peak_q, peak_d, peak_up, peak_dn;
    logic              sw, sw_d, bo_rise, val_ev, tout_wrap, wait_v, dly_go, dly_done;
    logic              blank, gate_off, cyc_end, ws_now, ws_trip, sc_trip, dl4, rec_done;
    logic              go_off, trip_lat;

    assign sw        = state_q == ST_RUN || state_q == ST_STOP;
    assign sw_d      = state_d == ST_RUN || state_d == ST_STOP;
    assign bo_rise   = bo_s && !bo_prev_q;
    assign line_hi_d = lhi_s ? 1'b1 : (llo_s ? 1'b0 : line_hi_q);
    assign band_d    = band_next(band_q, dim_level_i);
    assign tout_wrap = zv_s && tout_cnt_q == OW'(TOUT_CYC - 1);
    assign tout_cnt_d = (zv_s && !tout_wrap) ? tout_cnt_q + 1'b1 : '0;
    assign val_ev    = (zv_s && !zv_prev_q) || tout_wrap;
    assign wait_v    = sw && !gate_q && !dly_act_q;
    assign vcnt_d    = !wait_v ? 5'h00 : (val_ev ? vcnt_q + 5'h01 : vcnt_q);
    assign dly_go    = wait_v && val_ev && (5'(vcnt_q + 5'h01) >= valley_q);
    assign dly_done  = dly_act_q && dly_cnt_q == DW'(DLY_CYC - 1);
    assign dly_act_d = sw_d && (dly_go || (dly_act_q && !dly_done));
    assign blank     = gate_q && leb_cnt_q < LW'(LEB_CYC);
    assign ws_now    = csh_s && blank;
    assign ws_trip   = ws_cnt_q == 3'(`LFV_WS_CYCLES);
    assign gate_off  = (cpk_s && !blank) || ws_trip;
    assign gate_d    = sw_d && den_s && (dly_done || (gate_q && !gate_off));
    assign cyc_end   = gate_q && !gate_d;
    assign ws_hit_d  = gate_q && (ws_hit_q || ws_now);
    assign ws_cnt_d  = !sw ? 3'h0 : ((cyc_end && (ws_hit_q || ws_now)) ? ws_cnt_q + 3'h1 : ws_cnt_q);
    assign sc_cnt_d  = (sw && den_s && zs_s) ? ((tick_q && !sc_trip) ? sc_cnt_q + 1'b1 : sc_cnt_q) : '0;
    assign sc_trip   = sc_cnt_q == SW'(SHORT_TICKS);
    assign dl_cnt_d  = den_s ? '0 : ((tick_q && !dl4) ? dl_cnt_q + 1'b1 : dl_cnt_q);
    assign dl4       = dl_cnt_q == RW'(REC_TICKS);
    assign rec_cnt_d = (state_q == ST_AR) ? ((tick_q && !rec_done) ? rec_cnt_q + 1'b1 : rec_cnt_q) : '0;
    assign rec_done  = rec_cnt_q == RW'(REC_TICKS);
    assign go_off    = soff_s || tsd_s || bo_rise || (dl4 && state_q != ST_OFF);
    assign trip_lat  = (ovp_s || ws_trip) && latched_q;
    assign peak_up   = (peak_set_i - peak_q > STEP_V) ? peak_q + STEP_V : peak_set_i;
    assign peak_dn   = (peak_q > STEP_V) ? peak_q - STEP_V : '0;

    // ************************************************************
    // Mode sequencer.
    // ************************************************************
    always_comb begin
        state_d = state_q;
        if (go_off) begin
            state_d = ST_OFF;
        end else begin
            case (state_q)
                ST_OFF: begin
                    if (dhys_s && !bo_s) state_d = ST_FAULT;
                end
                ST_FAULT: begin
                    state_d = cpin_s ? ST_AR : ST_RUN;
                end
                ST_RUN, ST_STOP: begin
                    if (trip_lat) begin
                        state_d = ST_LATCH;
                    end else if (ovp_s || ws_trip || sc_trip) begin
                        state_d = ST_AR;
                    end else if (state_q == ST_RUN && !den_s) begin
                        state_d = ST_STOP;
                    end else if (state_q == ST_STOP && den_s) begin
                        state_d = ST_RUN;
                    end else if (state_q == ST_STOP && peak_q == '0 && !gate_q) begin
                        state_d = ST_AR;
                    end
                end
                ST_AR: begin
                    if (ar_dim_q && den_s) begin
                        state_d = ST_RUN;
                    end else if (!ar_dim_q && rec_done) begin
                        state_d = ST_OFF;
                    end
                end
                ST_LATCH: begin
                    state_d = ST_LATCH;
                end
                default: begin
                    state_d = ST_OFF;
                end
            endcase
        end
    end

    always_comb begin
        case (state_q)
            ST_RUN: begin
                peak_d = (peak_q >= peak_set_i) ? peak_set_i : (tick_q ? peak_up : peak_q);
            end
            ST_STOP: begin
                peak_d = tick_q ? peak_dn : peak_q;
            end
            default: begin
                peak_d = '0;
            end
        endcase
    end

    // ************************************************************
    // Registers.
    // ************************************************************
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q    <= ST_OFF;
            init_q     <= 2'h0;
            latched_q  <= 1'b0;
            bo_prev_q  <= 1'b0;
            zv_prev_q  <= 1'b0;
            ar_dim_q   <= 1'b0;
            line_hi_q  <= 1'b0;
            band_q     <= `LFV_BAND_RST;
            valley_q   <= `LFV_VALLEY_RST;
            vcnt_q     <= 5'h00;
            tout_cnt_q <= '0;
            dly_act_q  <= 1'b0;
            dly_cnt_q  <= '0;
            leb_cnt_q  <= '0;
            gate_q     <= 1'b0;
            ws_hit_q   <= 1'b0;
            ws_cnt_q   <= 3'h0;
            sc_cnt_q   <= '0;
            dl_cnt_q   <= '0;
            rec_cnt_q  <= '0;
            peak_q     <= '0;
        end else begin
            state_q    <= (init_q == 2'h3) ? state_d : ST_OFF;
            init_q     <= (init_q == 2'h3) ? init_q : init_q + 2'h1;
            latched_q  <= (init_q == 2'h3) ? latched_q : strap_s;
            bo_prev_q  <= bo_s;
            zv_prev_q  <= zv_s;
            ar_dim_q   <= (state_d == ST_AR && state_q != ST_AR) ? (state_q == ST_STOP) : ar_dim_q;
            line_hi_q  <= line_hi_d;
            band_q     <= band_d;
            valley_q   <= valley_of(band_q, line_hi_q, latched_q);
            vcnt_q     <= vcnt_d;
            tout_cnt_q <= tout_cnt_d;
            dly_act_q  <= dly_act_d;
            dly_cnt_q  <= dly_act_q ? dly_cnt_q + 1'b1 : '0;
            leb_cnt_q  <= !gate_q ? '0 : (blank ? leb_cnt_q + 1'b1 : leb_cnt_q);
            gate_q     <= gate_d;
            ws_hit_q   <= ws_hit_d;
            ws_cnt_q   <= ws_cnt_d;
            sc_cnt_q   <= sc_cnt_d;
            dl_cnt_q   <= dl_cnt_d;
            rec_cnt_q  <= rec_cnt_d;
            peak_q     <= peak_d;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lff_offset_en_o         <= 1'b0;
            off_mode_o              <= 1'b1;
            fault_mode_o            <= 1'b0;
            run_mode_o              <= 1'b0;
            ar_mode_o               <= 1'b0;
            latched_o               <= 1'b0;
            winding_short_protect_o <= 1'b0;
            short_timer_trip_o      <= 1'b0;
        end else begin
            lff_offset_en_o         <= gate_d;
            off_mode_o              <= state_d == ST_OFF;
            fault_mode_o            <= state_d == ST_FAULT;
            run_mode_o              <= sw_d;
            ar_mode_o               <= state_d == ST_AR;
            latched_o               <= state_d == ST_LATCH;
            winding_short_protect_o <= ws_trip && sw;
            short_timer_trip_o      <= sc_trip && sw;
        end
    end

    assign gate_drive_out_o = gate_q;
    assign peak_cmd_o       = peak_q;
    assign valley_sel_o     = valley_q;
    assign high_line_o      = line_hi_q;

    // ************************************************************
    // Assertions and covers.
    // ************************************************************
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    no_drive_idle_a: assert property (!sw |=> !gate_q)
        else $error("Gate driven outside switching modes.");
    ws_latch_a: assert property (sw && ws_trip && latched_q && !go_off |=> state_q == ST_LATCH)
        else $error("Winding short did not latch.");
    ws_ar_a: assert property (sw && ws_trip && !latched_q && !go_off |=> state_q == ST_AR)
        else $error("Winding short did not enter recovery.");
    latch_clear_a: assert property (state_q == ST_LATCH && soff_s |=> state_q == ST_OFF)
        else $error("Latch not cleared to off mode.");
    off_exit_a: assert property (state_q == ST_OFF ##1 state_q == ST_FAULT |-> $past(dhys_s))
        else $error("Off mode left without hysteresis level.");
    lff_gate_a: assert property (lff_offset_en_o == gate_q)
        else $error("Feed-forward offset not aligned to switch on-time.");
    soft_stop_a: assert property (state_q == ST_STOP ##1 state_q == ST_STOP |-> peak_q <= $past(peak_q))
        else $error("Peak command rose during soft stop.");
    scp_off_a: assert property (!den_s |=> sc_cnt_q == '0)
        else $error("Short timer ran with dimming low.");
    ws_clear_a: assert property (!sw |=> ws_cnt_q == 3'h0)
        else $error("Winding short count kept while idle.");
    turn_on_a: assert property ($rose(gate_q) |-> $past(dly_cnt_q) == DW'(DLY_CYC - 1))
        else $error("Switch turned on without valley delay.");

    gate_on_c: cover property ($rose(gate_q));
    stop_ar_c: cover property (state_q == ST_STOP ##1 state_q == ST_AR);
    latch_c:   cover property (state_q == ST_LATCH);
    rec_off_c: cover property (state_q == ST_AR && rec_done ##1 state_q == ST_OFF);
endmodule : lfv_ctrl

// [bench/lfv_plant_model.sv]
`timescale 1ns/1ps
// ****
// Switch and sensing network model.
// ****
module lfv_plant_model (
    // Clock and reset.
    input  wire logic clk_sys_i,
    input  wire logic nrst_i,
    // Gate and commanded faults.
    input  wire logic gate_i,
    input  wire logic wshort_i,
    input  wire logic oshort_i,
    // Comparator levels.
    output logic      cs_peak_o,
    output logic      cs_short_o,
    output logic      zcd_valley_o,
    output logic      zcd_short_o
);
    logic [7:0] cnt_q;
    logic       g_q;
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_q <= 8'h00;
            g_q   <= 1'b0;
        end else begin
            cnt_q <= (gate_i == g_q) ? cnt_q + 8'h01 : 8'h00;
            g_q   <= gate_i;
        end
    end
    assign cs_peak_o    = gate_i & (cnt_q >= 8'h50);
    assign cs_short_o   = wshort_i & gate_i & (cnt_q < 8'h1e);
    assign zcd_valley_o = oshort_i | (!gate_i & cnt_q[4]);
    assign zcd_short_o  = oshort_i;
endmodule : lfv_plant_model

// [bench/lfv_ctrl_tb_top.sv]
`timescale 1ns/1ps
// ****
// Bench for the fault and valley logic.
// ****
module lfv_ctrl_tb_top;
    import lfv_pkg::*;
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic lat_v, pin_sh, ovp, soff, bo, lhi, llo, den, dhy, wsh, osh, cpk, csh, zv, zs;
    logic trip_seen = 1'b0;
    logic [6:0] dim_lv;
    logic [7:0] mon;
    logic [7:0] peak;
    logic [4:0] vsel;
    logic gate, lff, hl, off, flt, run, ar, lch, wsp, trip;
    int fail_count = 0;
    int n_compared = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    assign mon = {trip, wsp, lch, ar, run, flt, off, gate};
    always @(posedge clk_sys_i) if (trip === 1'b1) trip_seen <= 1'b1;
    lfv_ctrl #(.REC_TICKS(20), .SHORT_TICKS(10)) lfv_ctrl_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .latched_variant_i(lat_v),
        .cs_short_cmp_i(csh), .cs_peak_cmp_i(cpk), .cs_pin_short_i(pin_sh),
        .zcd_valley_cmp_i(zv), .zcd_short_cmp_i(zs), .dim_en_cmp_i(den),
        .dim_hys_cmp_i(dhy), .supply_ovp_cmp_i(ovp), .supply_off_cmp_i(soff),
        .line_low_fault_i(bo), .line_hi_cmp_i(lhi), .line_lo_cmp_i(llo),
        .thermal_shutdown_i(1'b0), .dim_level_i(dim_lv), .peak_set_i(8'h40),
        .gate_drive_out_o(gate), .lff_offset_en_o(lff), .peak_cmd_o(peak),
        .valley_sel_o(vsel), .high_line_o(hl), .off_mode_o(off), .fault_mode_o(flt),
        .run_mode_o(run), .ar_mode_o(ar), .latched_o(lch),
        .winding_short_protect_o(wsp), .short_timer_trip_o(trip));
    lfv_plant_model lfv_plant_model_inst (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .gate_i(gate), .wshort_i(wsh),
        .oshort_i(osh), .cs_peak_o(cpk), .cs_short_o(csh), .zcd_valley_o(zv),
        .zcd_short_o(zs));
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step
    task automatic waitb(input int b, input int lim, input logic exp, input string nm);
        int i;
        i = 0;
        while (i < lim && mon[b] !== 1'b1) begin
            step(1);
            i++;
        end
        chk(nm, {7'h00, mon[b]}, {7'h00, exp});
    endtask : waitb
    task automatic rst(input logic lv);
        nrst_i = 1'b0;
        lat_v = lv;
        {pin_sh, ovp, soff, bo, lhi, wsh, osh} = 7'h00;
        {llo, den, dhy} = 3'h7;
        dim_lv = 7'h64;
        step(6);
        chk("off at reset", {7'h00, off}, 8'h01);
        chk("valley at reset", {3'h0, vsel}, 8'h01);
        nrst_i = 1'b1;
    endtask : rst
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test
    // Watchdog sized at about twice the expected run.
    initial begin
        repeat (60000) @(posedge clk_sys_i);
        fail_count++;
        end_of_test();
    end
    initial begin
        static logic [6:0] lv_tab [8] = '{7'h4d, 7'h31, 7'h1d, 7'h0e, 7'h05, 7'h07, 7'h09, 7'h64};
        static int vb_tab [8] = '{1, 2, 3, 4, 5, 5, 4, 0};
        rst(1'b0);
        waitb(3, 200, 1'b1, "run at start");
        waitb(0, 2000, 1'b1, "first pulse");
        repeat (300) begin
            step(1);
            chk("offset enable", {7'h00, lff}, {7'h00, gate});
        end
        foreach (lv_tab[i]) begin
            dim_lv = lv_tab[i];
            step(6);
            chk("valley low line", {3'h0, vsel}, {3'h0, LFV_VLL[vb_tab[i]]});
        end
        {lhi, llo} = 2'h2;
        step(6);
        chk("high line", {7'h00, hl}, 8'h01);
        chk("valley high line", {3'h0, vsel}, {3'h0, LFV_VHB[0]});
        lhi = 1'b0;
        step(6);
        chk("line hysteresis", {7'h00, hl}, 8'h01);
        llo = 1'b1;
        step(6);
        chk("low line", {7'h00, hl}, 8'h00);
        $display("test start and valley done");
        {osh, den, dhy} = 3'h4;
        step(10);
        chk("gate dim low", {7'h00, gate}, 8'h00);
        for (int i = 0; i < 40000 && peak !== 8'h00; i++) step(1);
        chk("soft stop", peak, 8'h00);
        waitb(1, 5000, 1'b1, "off after dim");
        chk("short timer idle", {7'h00, trip_seen}, 8'h00);
        den = 1'b1;
        step(50);
        chk("off held", {7'h00, off}, 8'h01);
        dhy = 1'b1;
        waitb(3, 100, 1'b1, "run after dim");
        waitb(7, 3000, 1'b1, "short trip");
        waitb(4, 5, 1'b1, "ar after trip");
        osh = 1'b0;
        waitb(1, 5000, 1'b1, "off after trip");
        waitb(3, 200, 1'b1, "restart");
        $display("test dimming and short timer done");
        wsh = 1'b1;
        waitb(6, 3000, 1'b1, "winding short");
        waitb(4, 5, 1'b1, "ar winding");
        wsh = 1'b0;
        waitb(1, 5000, 1'b1, "off winding");
        waitb(3, 200, 1'b1, "run winding");
        ovp = 1'b1;
        waitb(4, 10, 1'b1, "ar ovp");
        ovp = 1'b0;
        waitb(1, 5000, 1'b1, "off ovp");
        waitb(2, 100, 1'b1, "fault ovp");
        $display("test auto recovery done");
        rst(1'b1);
        pin_sh = 1'b1;
        waitb(4, 200, 1'b1, "ar pin short");
        pin_sh = 1'b0;
        waitb(1, 5000, 1'b1, "off pin short");
        waitb(3, 200, 1'b1, "run latched");
        wsh = 1'b1;
        waitb(5, 3000, 1'b1, "latch winding");
        wsh = 1'b0;
        step(4500);
        chk("latch held", {6'h00, lch, gate}, 8'h02);
        soff = 1'b1;
        waitb(1, 10, 1'b1, "off supply");
        chk("latch clear", {7'h00, lch}, 8'h00);
        soff = 1'b0;
        waitb(3, 200, 1'b1, "run again");
        {lhi, llo} = 2'h2;
        step(6);
        chk("valley latched", {3'h0, vsel}, {3'h0, LFV_VHA[0]});
        ovp = 1'b1;
        waitb(5, 10, 1'b1, "latch ovp");
        ovp = 1'b0;
        bo = 1'b1;
        waitb(1, 10, 1'b1, "off brownout");
        chk("ovp latch clear", {7'h00, lch}, 8'h00);
        $display("test latched variant done");
        end_of_test();
    end
endmodule : lfv_ctrl_tb_top
